/* pdwl_defs.vh */
// constants for the peripheral disable write lock
`ifndef PDWL_DEFS_VH
`define PDWL_DEFS_VH

`define PDWL_LOCK_BIT      12
`define PDWL_ONEWAY_BIT    28
`define PDWL_LOCK_RST      1'b0
`define PDWL_DIS_W         32
`define PDWL_DIS_N         4
`define PDWL_IDX_W         2
`define PDWL_DIS_RST       32'h0000_0000

`endif

/* pdwl_lock.v */
// write lock guarding the module disable registers
// Operation
// - lock active: writes to module disable registers rejected, contents kept
// - rejected write completes like normal; no error, no stall
// - lock lives in config control bit 12; sole source of write permission
// - lock one blocks disable writes; lock zero lets them update
// - lock bit changes only after an unlock sequence; others ignored
// - one-way option (config word3 bit 28) forbids clearing a set lock
// - one-way and locked: unlock has no effect, pin select writes refused
// - under one-way only device reset clears the lock
`include "pdwl_defs.vh"
`default_nettype none

module pdwl_lock (
   // clock and device reset
   input  wire                       mclk_i,
   input  wire                       rst_i,
   // config control writes and the unlock sequence
   input  wire                       cfg_wr_i,
   input  wire [31:0]                cfg_wdata_i,
   input  wire                       unlock_permit_i,
   input  wire [31:0]                device_config_word3_i,
   // module disable and pin select write requests
   input  wire                       dis_wr_i,
   input  wire [`PDWL_IDX_W-1:0]     dis_idx_i,
   input  wire [`PDWL_DIS_W-1:0]     dis_wdata_i,
   input  wire                       pin_select_wr_i,
   // lock status and write outcomes, all registered
   output reg                        disable_reg_lock_o,
   output reg                        unlock_open_o,
   output reg                        dis_wr_done_o,
   output reg                        dis_wr_rejected_o,
   output reg                        pin_select_wr_en_o,
   output wire [`PDWL_DIS_N*`PDWL_DIS_W-1:0] module_disable_regs_o
);

   // permit window states; dead parks a one-way lock that is stuck on
   localparam [1:0] PM_IDLE  = 2'h0;
   localparam [1:0] PM_ARMED = 2'h1;
   localparam [1:0] PM_DEAD  = 2'h2;

   // lock register state and its next value
   reg                      lock_r;
   reg                      lock_nxt;

   // unlock permit state machine
   reg  [1:0]               pm_state_r;
   reg  [1:0]               pm_state_nxt;

   // decoded conditions used by the processes below
   wire                     permit_armed;
   wire                     one_way;
   wire                     hard_locked;
   wire                     permit_arm;
   wire                     lock_wr;
   wire                     want_set;
   wire                     want_clr;
   wire                     dis_wr_ok;
   wire                     dis_wr_bad;
   wire                     pin_ok;
   wire [`PDWL_DIS_N-1:0]   one_hot;
   wire [`PDWL_DIS_N-1:0]   slot_sel;
   genvar                   g;

   // armed state is the only one that qualifies a lock write
   assign permit_armed = (pm_state_r == PM_ARMED);

   // one-way option sampled live; software is expected to keep it static
   assign one_way     = device_config_word3_i[`PDWL_ONEWAY_BIT];

   // one-way plus set lock: unlock and pin select both go dead
   assign hard_locked = one_way & lock_r;

   // an unlock completion only counts while the lock can still move
   assign permit_arm  = unlock_permit_i & ~hard_locked;

   // a lock write is qualified only by an already armed permit
   assign lock_wr     = cfg_wr_i & permit_armed;
   assign want_set    = lock_wr &  cfg_wdata_i[`PDWL_LOCK_BIT];
   assign want_clr    = lock_wr & ~cfg_wdata_i[`PDWL_LOCK_BIT];

   // the lock bit alone decides disable write permission
   assign dis_wr_ok   = dis_wr_i & ~lock_r;
   assign dis_wr_bad  = dis_wr_i &  lock_r;

   // pin select requests pass unless the lock is stuck on
   assign pin_ok      = pin_select_wr_i & ~hard_locked;

   // one select line per disable register; none when the write is refused
   assign one_hot  = {{(`PDWL_DIS_N-1){1'b0}}, 1'b1} << dis_idx_i;
   assign slot_sel = dis_wr_ok ? one_hot : {`PDWL_DIS_N{1'b0}};

   // permit stays armed until the next config write uses it up; an arm in
   // the same cycle wins, so a racing write cannot swallow a fresh permit
   always @* begin
      pm_state_nxt = pm_state_r;
      case (pm_state_r)
         PM_IDLE: begin
            if (permit_arm) begin
               pm_state_nxt = PM_ARMED;
            end else if (hard_locked) begin
               pm_state_nxt = PM_DEAD;
            end
         end
         PM_ARMED: begin
            if (permit_arm) begin
               pm_state_nxt = PM_ARMED;
            end else if (cfg_wr_i) begin
               pm_state_nxt = PM_IDLE;
            end
         end
         PM_DEAD: begin
            if (!hard_locked) begin
               pm_state_nxt = PM_IDLE;
            end
         end
         default: begin
            pm_state_nxt = PM_IDLE;
         end
      endcase
   end

   // permit state register, cleared by device reset
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pm_state_r <= PM_IDLE;
      end else begin
         pm_state_r <= pm_state_nxt;
      end
   end

   // next lock value; a clear is barred once the one-way option is on
   always @* begin
      lock_nxt = lock_r;
      if (want_set) begin
         lock_nxt = 1'b1;
      end else if (want_clr && !one_way) begin
         lock_nxt = 1'b0;
      end
   end

   // only reset drops a one-way lock
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_r <= `PDWL_LOCK_RST;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   // every disable write completes; the lock only decides whether it lands
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dis_wr_done_o     <= 1'b0;
         dis_wr_rejected_o <= 1'b0;
      end else begin
         dis_wr_done_o     <= dis_wr_i;
         dis_wr_rejected_o <= dis_wr_bad;
      end
   end

   // one storage slot per disable register, reg0 in the low bits
   generate
      for (g = 0; g < `PDWL_DIS_N; g = g + 1) begin : dis_slot
         pdwl_dis_slot pdwl_dis_slot_i (
            .mclk_i  (mclk_i),
            .rst_i   (rst_i),
            .wr_en_i (slot_sel[g]),
            .wdata_i (dis_wdata_i),
            .q_o     (module_disable_regs_o[g*`PDWL_DIS_W +: `PDWL_DIS_W])
         );
      end
   endgenerate

   // lock status mirrors the next lock value, so it agrees with lock_r
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         disable_reg_lock_o <= 1'b0;
      end else begin
         disable_reg_lock_o <= lock_nxt;
      end
   end

   // permit status lags the internal window by one cycle
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         unlock_open_o <= 1'b0;
      end else begin
         unlock_open_o <= permit_armed;
      end
   end

   // pin select grant, dead while the one-way lock is stuck on
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_select_wr_en_o <= 1'b0;
      end else begin
         pin_select_wr_en_o <= pin_ok;
      end
   end

endmodule

// one module disable register; it sees only writes the lock let through
module pdwl_dis_slot #(
   parameter [`PDWL_DIS_W-1:0] RST_VAL = `PDWL_DIS_RST
) (
   input  wire                   mclk_i,
   input  wire                   rst_i,
   input  wire                   wr_en_i,
   input  wire [`PDWL_DIS_W-1:0] wdata_i,
   output reg  [`PDWL_DIS_W-1:0] q_o
);

   // refused writes never reach here, so the stored value simply holds
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o <= RST_VAL;
      end else if (wr_en_i) begin
         q_o <= wdata_i;
      end
   end

endmodule

`default_nettype wire

/* pdwl_lock_assertions.sv */
// checker for the disable write lock ports
`default_nettype none
module pdwl_lock_assertions (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        cfg_wr_i,
   input wire logic        dis_wr_i,
   input wire logic        pin_select_wr_i,
   input wire logic [31:0] device_config_word3_i,
   input wire logic        dis_wr_done_o,
   input wire logic        dis_wr_rejected_o,
   input wire logic        disable_reg_lock_o,
   input wire logic        pin_select_wr_en_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_done_next: assert property (dis_wr_i |=> dis_wr_done_o)
      else $error("write done missing");
   a_done_idle: assert property (!dis_wr_i |=>
      !dis_wr_done_o && !dis_wr_rejected_o) else $error("stray done");
   a_reject_lock: assert property (dis_wr_i |=>
      dis_wr_rejected_o == $past(disable_reg_lock_o)) else $error("reject");
   a_lock_still: assert property (!cfg_wr_i |=>
      $stable(disable_reg_lock_o)) else $error("lock moved");
   a_oneway_keep: assert property (device_config_word3_i[28] &&
      disable_reg_lock_o |=> disable_reg_lock_o) else $error("lock cleared");
   a_pin_block: assert property (pin_select_wr_i |=>
      pin_select_wr_en_o !=
      ($past(device_config_word3_i[28]) && $past(disable_reg_lock_o)))
      else $error("pin select");
endmodule
`default_nettype wire

/* pdwl_lock_test.sv */
// self-checking bench for the disable write lock
`default_nettype none
`define CHK(n,e,v) begin total_checks++; if ((v) !== (e)) begin n_fail++; \
 $display("wrong value %s exp %h got %h", n, e, v); end end
module pdwl_lock_test;
timeunit 1ns; timeprecision 1ps;
logic mclk_i = 0, rst_i = 1, cw = 0, pm = 0, dw = 0, pw = 0, lk, uo, dn, rj, pe;
logic [31:0] cd = 0, w3 = 0, dd = 0; logic [1:0] ix = 0; logic [127:0] regs;
int n_fail = 0, total_checks = 0;
always #2 mclk_i = ~mclk_i;
pdwl_lock pdwl_lock_i (.mclk_i, .rst_i, .cfg_wr_i(cw), .cfg_wdata_i(cd),
   .unlock_permit_i(pm), .device_config_word3_i(w3), .dis_wr_i(dw),
   .dis_idx_i(ix), .dis_wdata_i(dd), .pin_select_wr_i(pw),
   .disable_reg_lock_o(lk), .unlock_open_o(uo), .dis_wr_done_o(dn),
   .dis_wr_rejected_o(rj), .pin_select_wr_en_o(pe),
   .module_disable_regs_o(regs));
// one disable write, judged one cycle later
task dwr(input [1:0] i, input [31:0] d, input r);
   @(negedge mclk_i) dw = 1; ix = i; dd = d;
   @(negedge mclk_i) dw = 0;
   `CHK("done", 1'h1, dn)
   `CHK("reject", r, rj)
endtask
// optional permit, then a lock write; o is the permit window expected
task cwr(input p, input b, input o);
   @(negedge mclk_i) pm = p;
   @(negedge mclk_i) pm = 0; cw = 1; cd = {19'h0, b, 12'h0};
   @(negedge mclk_i) cw = 0;
   `CHK("open", o, uo)
endtask
// one pin select request, grant judged one cycle later
task pwr(input e);
   @(negedge mclk_i) pw = 1;
   @(negedge mclk_i) pw = 0;
   `CHK("pin en", e, pe)
endtask
task t_open;
   dwr(2'h3, 32'ha5, 1'h0);
   `CHK("reg3", 32'ha5, regs[127:96])
   pwr(1'h1);
   $display("open test over");
endtask
task t_lock;
   cwr(1'h0, 1'h1, 1'h0);
   `CHK("lock", 1'h0, lk)
   cwr(1'h1, 1'h1, 1'h1);
   `CHK("lock", 1'h1, lk)
   dwr(2'h3, 32'h5a, 1'h1);
   `CHK("reg3", 32'ha5, regs[127:96])
   cwr(1'h1, 1'h0, 1'h1);
   `CHK("lock", 1'h0, lk)
   $display("lock test over");
endtask
task t_oneway;
   w3 = 32'h1000_0000;
   cwr(1'h1, 1'h1, 1'h1);
   cwr(1'h1, 1'h0, 1'h0); // permit dead while stuck
   `CHK("lock", 1'h1, lk)
   pwr(1'h0);
   rst_i = 1;
   @(negedge mclk_i) rst_i = 0;
   `CHK("lock", 1'h0, lk)
   `CHK("regs", 128'h0, regs)
   dwr(2'h0, 32'h77, 1'h0);
   `CHK("reg0", 32'h77, regs[31:0])
   $display("one-way test over");
endtask
task conclude;
   $display("checks %0d mismatches %0d", total_checks, n_fail);
   if (n_fail == 0 && total_checks > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
endtask
initial begin
   repeat (12) @(negedge mclk_i);
   rst_i = 0;
   t_open; t_lock; t_oneway; conclude;
end
endmodule
bind pdwl_lock pdwl_lock_assertions pdwl_lock_assertions_i (.*);
`default_nettype wire
